/* verif/asr_host_properties.sv */
// pin-timing checker for the static ram host controller
`timescale 1ns/100ps
`default_nettype none
module asr_host_properties (
   input wire logic mclk,
   input wire logic reset,
   input wire logic rsp_valid,
   input wire logic [15:0] word_address,
   input wire logic chip_select_n,
   input wire logic output_enable_n,
   input wire logic write_enable_n,
   input wire logic [15:0] shared_data_bus_out,
   input wire logic [15:0] shared_data_bus_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_wend; $rose(write_enable_n); endsequence // write end
   property p_rd_we; !chip_select_n && !output_enable_n |-> write_enable_n;
   endproperty
   a_rd_we: assert property (p_rd_we) else $error("write during read");
   property p_fight; !output_enable_n |-> shared_data_bus_oe == 16'h0;
   endproperty
   a_fight: assert property (p_fight) else $error("bus fight");
   property p_wr; !write_enable_n |-> output_enable_n && |shared_data_bus_oe;
   endproperty
   a_wr: assert property (p_wr) else $error("write not driven");
   property p_sd; s_wend |-> $past(shared_data_bus_out, 3) == shared_data_bus_out;
   endproperty
   a_sd: assert property (p_sd) else $error("data setup short");
   property p_aw; s_wend |-> $past(word_address, 4) == word_address;
   endproperty
   a_aw: assert property (p_aw) else $error("address setup short");
   property p_end; s_wend |=> chip_select_n && shared_data_bus_oe == 16'h0;
   endproperty
   a_end: assert property (p_end) else $error("write end wrong");
   property p_cs; $fell(chip_select_n) |=> $stable(word_address) [*3];
   endproperty
   a_cs: assert property (p_cs) else $error("address moved");
   property p_rt; $fell(output_enable_n) |-> ##4 rsp_valid; endproperty
   a_rt: assert property (p_rt) else $error("read answer late");
endmodule // asr_host_properties
bind asr_host asr_host_properties u_prop (.mclk(mclk), .reset(reset),
   .rsp_valid(rsp_valid), .word_address(word_address),
   .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
   .write_enable_n(write_enable_n), .shared_data_bus_out(shared_data_bus_out),
   .shared_data_bus_oe(shared_data_bus_oe));
`default_nettype wire

/* verif/asr_host_tb.sv */
// self-checking bench for the static ram host controller
`timescale 1ns/100ps
`default_nettype none
module asr_host_tb;
   logic mclk = 0, reset = 1, req_valid = 0, req_write = 0;
   logic [15:0] req_addr = 0, req_wdata = 0, q;
   logic [1:0] req_lanes = 0;
   logic req_ready, rsp_valid, csn, oen, wen, lbn, hbn;
   logic [15:0] rsp_rdata, adr, bo, boe, bi, bw;
   int fails = 0, checked = 0;
   assign bw = (bo & boe) | (bi & ~boe); // resolved data wire
   always #12.5 mclk = ~mclk; // 40 mhz
   asr_host DUT (.mclk(mclk), .reset(reset), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_lanes(req_lanes), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .word_address(adr), .chip_select_n(csn),
      .output_enable_n(oen), .write_enable_n(wen), .low_byte_enable_n(lbn),
      .high_byte_enable_n(hbn), .shared_data_bus_in(bi),
      .shared_data_bus_out(bo), .shared_data_bus_oe(boe));
   asr_sram_model u_mem (.word_address(adr), .chip_select_n(csn),
      .output_enable_n(oen), .write_enable_n(wen), .low_byte_enable_n(lbn),
      .high_byte_enable_n(hbn), .bus_drv(bw), .bus_rd(bi));
   // compare one value
   task automatic chk(input string n, input logic [15:0] e, s);
      checked++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // one access, held until taken
   task automatic acc(input logic w, input logic [15:0] a, d,
      input logic [1:0] l);
      int i;
      // one edge between accesses: valid never toggles twice in a step
      @(posedge mclk) #1;
      {req_write, req_addr, req_wdata, req_lanes, req_valid} =
         {w, a, d, l, 1'b1};
      for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(posedge mclk) #1;
      chk("req_ready", 16'h1, {15'h0, req_ready});
      @(posedge mclk) #1;
      req_valid = 1'b0;
   endtask
   // read and wait for the answer
   task automatic rd(input logic [15:0] a, input logic [1:0] l);
      int i;
      acc(0, a, 16'h0, l);
      for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(posedge mclk) #1;
      chk("rsp_valid", 16'h1, {15'h0, rsp_valid});
      q = rsp_rdata;
   endtask
   task automatic t_word;
      acc(1, 16'h0000, 16'h1234, 2'h3);
      acc(1, 16'hffff, 16'hc3a5, 2'h3);
      rd(16'h0000, 2'h3);
      chk("word0", 16'h1234, q);
      rd(16'hffff, 2'h3);
      chk("wordtop", 16'hc3a5, q);
      $display("t_word done");
   endtask
   task automatic t_lanes;
      acc(1, 16'h0000, 16'h5566, 2'h1);
      acc(1, 16'h0000, 16'h7788, 2'h2);
      rd(16'h0000, 2'h3);
      chk("lanes", 16'h7766, q);
      rd(16'h0000, 2'h1);
      chk("lowlane", 16'h0066, q & 16'h00ff);
      $display("t_lanes done");
   endtask
   task automatic t_refuse;
      int i;
      {req_lanes, req_valid} = {2'h0, 1'b1};
      for (i = 0; i < 8; i++) begin
         @(posedge mclk) #1;
         chk("standby", 16'h1, {15'h0, csn});
      end
      req_valid = 0;
      $display("t_refuse done");
   endtask
   task automatic summarize;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      #1 reset = 0;
      chk("ready", 16'h1, {15'h0, req_ready});
      chk("reset cs", 16'h1, {15'h0, csn});
      chk("reset lanes", 16'h3, {14'h0, hbn, lbn});
      t_word;
      t_lanes;
      t_refuse;
      summarize;
   end
   initial begin
      #100000;
      $display("[ERR] watchdog expected done seen timeout");
      fails++;
      summarize;
   end
endmodule // asr_host_tb
`default_nettype wire

/* verif/asr_sram_model.sv */
// behavioural model of the 64k x 16 static ram
`timescale 1ns/100ps
`default_nettype none
module asr_sram_model (
   input wire logic [15:0] word_address,
   input wire logic chip_select_n,
   input wire logic output_enable_n,
   input wire logic write_enable_n,
   input wire logic low_byte_enable_n,
   input wire logic high_byte_enable_n,
   input wire logic [15:0] bus_drv,
   output logic [15:0] bus_rd
);
   logic [15:0] mem [0:65535]; // static words, no clock
   logic [1:0] wl; // lanes held during the write
   logic [15:0] wd; // data held during the write
   logic [15:0] q; // addressed word
   logic wr; // internal write overlap
   logic rd; // read drive allowed
   assign wr = !chip_select_n && !write_enable_n &&
      !(low_byte_enable_n && high_byte_enable_n);
   assign rd = !chip_select_n && !output_enable_n && write_enable_n;
   assign q = mem[word_address]; // held while address holds
   // track lanes and data while the write lasts
   always @* if (wr) begin
      wl = {!high_byte_enable_n, !low_byte_enable_n};
      wd = bus_drv;
   end
   // store when any qualifier ends the write
   always @(negedge wr) begin
      if (wl[0]) mem[word_address][7:0] = wd[7:0];
      if (wl[1]) mem[word_address][15:8] = wd[15:8];
   end
   // released lanes show the inverse word
   assign bus_rd[7:0] = (rd && !low_byte_enable_n) ? q[7:0] : ~q[7:0];
   assign bus_rd[15:8] = (rd && !high_byte_enable_n) ? q[15:8] : ~q[15:8];
endmodule // asr_sram_model
`default_nettype wire

/* verilog/asr_defs.svh */
// timing and pin-level constants for the static ram host controller
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH
// clock period in picoseconds (40 mhz)
`define ASR_CLK_PS 25000
// read cycle and address access time, ns
`define ASR_T_RC_NS 100
// write data setup to write end, ns
`define ASR_T_SD_NS 60
// address setup to write end and write pulse width, ns
`define ASR_T_AW_NS 80
// least time from one access end to the next, ns
`define ASR_T_GAP_NS 25
// cycle counts: least times round up
`define ASR_RD_CYC ((`ASR_T_RC_NS*1000+`ASR_CLK_PS-1)/`ASR_CLK_PS)
`define ASR_WR_CYC ((`ASR_T_AW_NS*1000+`ASR_CLK_PS-1)/`ASR_CLK_PS)
`define ASR_SD_CYC ((`ASR_T_SD_NS*1000+`ASR_CLK_PS-1)/`ASR_CLK_PS)
`define ASR_GAP_CYC ((`ASR_T_GAP_NS*1000+`ASR_CLK_PS-1)/`ASR_CLK_PS)
// inactive level of an active-low strobe
`define ASR_OFF 1'b1
`define ASR_ON 1'b0
`endif

/* verilog/asr_host.sv */
// host controller that drives a 64k x 16 asynchronous static ram
`timescale 1ns/100ps
`default_nettype none
`include "asr_defs.svh"
module asr_host #(
   parameter int ADDR_W = 16, // word address width
   parameter int DATA_W = 16, // data width
   parameter int RD_CYC = `ASR_RD_CYC, // read access cycles
   parameter int WR_CYC = `ASR_WR_CYC, // write pulse cycles
   parameter int SD_CYC = `ASR_SD_CYC, // data setup cycles
   parameter int GAP_CYC = `ASR_GAP_CYC // idle cycles between accesses
) (
   input wire logic mclk,
   input wire logic reset,
   // user request side
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   input wire logic [1:0] req_lanes,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   // memory pins
   output logic [ADDR_W-1:0] word_address,
   output logic chip_select_n,
   output logic output_enable_n,
   output logic write_enable_n,
   output logic low_byte_enable_n,
   output logic high_byte_enable_n,
   input wire logic [DATA_W-1:0] shared_data_bus_in,
   output logic [DATA_W-1:0] shared_data_bus_out,
   output logic [DATA_W-1:0] shared_data_bus_oe
);
   localparam int HALF = DATA_W / 2; // width of one byte lane
   localparam int CNT_W = 8; // width of the cycle counter
   // the write pulse must cover both the address and the data setup,
   // so the longer of the two counts sets its length
   localparam int WR_HOLD = (WR_CYC > SD_CYC) ? WR_CYC : SD_CYC;
   // limitation: every count must fit in CNT_W bits, 255 at most

   asr_pkg::asr_state_e state, next_state; // sequence state
   logic [CNT_W-1:0] cnt, next_cnt; // cycles left in this phase
   logic [ADDR_W-1:0] next_word_address; // address to present
   logic [DATA_W-1:0] wdata, next_wdata; // held write data
   logic [1:0] lanes, next_lanes; // held lane enables, bit0 low lane
   logic cs_n, next_cs_n; // registered chip select
   logic oe_n, next_oe_n; // registered output enable
   logic we_n, next_we_n; // registered write enable
   logic drive, next_drive; // host drives the data bus
   logic next_rsp_valid; // read answer pulse
   logic [DATA_W-1:0] next_rsp_rdata; // captured read word

   // ready only while idle: one access at a time
   // a request with no lane set is still taken, as ready ignores the lanes,
   // but starts no access: the memory stays in standby and a read gets no answer
   assign req_ready = (state == asr_pkg::ASR_IDLE);

   // pins come straight from flip-flops
   // registered strobes cannot glitch, so no write starts by accident
   assign chip_select_n = cs_n;
   assign output_enable_n = oe_n;
   assign write_enable_n = we_n;
   // lane strobes follow select so an idle bus sits in standby
   assign low_byte_enable_n = ~lanes[0];
   assign high_byte_enable_n = ~lanes[1];
   assign shared_data_bus_out = wdata;

   // lane-wise output enables, one per bit
   // a write drives only the lanes it stores; the other lane stays free
   genvar gi;
   generate
      for (gi = 0; gi < DATA_W; gi++) begin : g_oe
         // host drives a lane only while writing it
         assign shared_data_bus_oe[gi] = drive & lanes[gi / HALF];
      end
   endgenerate

   // next-state logic of the access sequencer
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_word_address = word_address;
      next_wdata = wdata;
      next_lanes = lanes;
      next_cs_n = cs_n;
      next_oe_n = oe_n;
      next_we_n = we_n;
      next_drive = drive;
      next_rsp_valid = 1'b0;
      next_rsp_rdata = rsp_rdata;
      unique case (state)
         asr_pkg::ASR_IDLE: begin
            // address and select leave together
            if (req_valid && req_lanes != 2'b00) begin
               next_word_address = req_addr;
               next_lanes = req_lanes;
               next_wdata = req_wdata;
               next_cs_n = `ASR_ON;
               if (req_write) begin
                  // write enable low with data driven
                  next_we_n = `ASR_ON;
                  next_oe_n = `ASR_OFF; // bus free for write data
                  next_drive = 1'b1;
                  next_cnt = CNT_W'(WR_HOLD);
                  next_state = asr_pkg::ASR_WR;
               end else begin
                  // read keeps write enable high
                  next_we_n = `ASR_OFF;
                  next_oe_n = `ASR_ON;
                  next_drive = 1'b0;
                  next_cnt = CNT_W'(RD_CYC);
                  next_state = asr_pkg::ASR_RD;
               end
            end
         end
         asr_pkg::ASR_RD: begin
            // wait full access time then sample
            // select and output enable stay low up to the sample edge,
            // so the bus never floats while the word is taken
            if (cnt <= 8'h01) begin
               next_rsp_rdata = shared_data_bus_in;
               next_rsp_valid = 1'b1;
               // release bus by select and output enable
               next_cs_n = `ASR_OFF;
               next_oe_n = `ASR_OFF;
               next_lanes = 2'b00;
               next_cnt = CNT_W'(GAP_CYC);
               next_state = asr_pkg::ASR_GAP;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         asr_pkg::ASR_WR: begin
            // address and data held for the whole pulse
            if (cnt <= 8'h01) begin
               // write enable rising ends the write
               next_we_n = `ASR_OFF;
               next_state = asr_pkg::ASR_WEND;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         asr_pkg::ASR_WEND: begin
            // data held one cycle past the end, address may move
            // select rises a cycle after write enable, so the write always
            // ends on write enable and the data hold is a full cycle
            next_cs_n = `ASR_OFF;
            next_lanes = 2'b00;
            next_drive = 1'b0;
            next_cnt = CNT_W'(GAP_CYC);
            next_state = asr_pkg::ASR_GAP;
         end
         asr_pkg::ASR_GAP: begin
            // idle spacing before the next access
            // lets the memory release its outputs before a new select
            if (cnt <= 8'h01) begin
               next_state = asr_pkg::ASR_IDLE;
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         default: begin
            // illegal code: back to a safe idle
            // codes above the gap state are never reached in normal running
            next_state = asr_pkg::ASR_IDLE;
            next_cs_n = `ASR_OFF;
            next_we_n = `ASR_OFF;
            next_oe_n = `ASR_OFF;
            next_drive = 1'b0;
            next_lanes = 2'b00;
         end
      endcase
   end

   // registers of the access sequencer
   // synchronous reset puts every strobe high: the memory sits in standby
   always_ff @(posedge mclk) begin
      if (reset) begin
         state <= asr_pkg::ASR_IDLE;
         cnt <= 8'h00;
         word_address <= '0;
         wdata <= '0;
         lanes <= 2'b00;
         cs_n <= `ASR_OFF; // standby from reset
         oe_n <= `ASR_OFF;
         we_n <= `ASR_OFF;
         drive <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         word_address <= next_word_address;
         wdata <= next_wdata;
         lanes <= next_lanes;
         cs_n <= next_cs_n;
         oe_n <= next_oe_n;
         we_n <= next_we_n;
         drive <= next_drive;
         rsp_valid <= next_rsp_valid;
         rsp_rdata <= next_rsp_rdata;
      end
   end
endmodule // asr_host
`default_nettype wire

/* verilog/asr_pkg.sv */
// types for the static ram host controller
`default_nettype none
package asr_pkg;
   // controller sequence states
   typedef enum logic [2:0] {
      ASR_IDLE = 3'b000,
      ASR_RD = 3'b001,
      ASR_WR = 3'b010,
      ASR_WEND = 3'b011,
      ASR_GAP = 3'b100
   } asr_state_e;
endpackage
`default_nettype wire
